/* src/charger_config_status_regs.sv */
// Charger termination, timer, compensation, misc control and status registers
`include "charger_regs_defines.svh"
`default_nettype none
module charger_config_status_regs
  import charger_regs_pkg::*;
#(
  parameter logic [35:0] WDOG_UNIT_CYCLES = 36'(`WDOG_UNIT_S * `CLK_HZ),
  parameter logic [39:0] HOUR_CYCLES      = 40'(`HOUR_S * `CLK_HZ)
) (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output var  logic       sdaOe,
  input  wire sysStatus_t sysStatus,
  input  wire logic [1:0] chargeFaultCode,
  input  wire logic       batteryOvervoltFlag,
  input  wire logic       usbDetectDone,
  input  wire logic       currentBelowEarly,
  input  wire logic       batterySwitchReq,
  output termTimerReg_t   cfgTermTimer,
  output irCompReg_t      cfgIrComp,
  output miscReg_t        cfgMisc,
  output logic            chargeDoneInd,
  output logic            hostTimeoutExpired,
  output logic            safetyTimerExpired,
  output logic            batterySwitchOn,
  output logic            intPulse
);

  regReq_t       req;
  logic [7:0]    rdAddr;
  logic [7:0]    rdData;
  termTimerReg_t termTimer_q;
  irCompReg_t    irComp_q;
  miscReg_t      misc_q;
  logic [1:0]    faultPrev_q;
  logic          ovPrev_q;
  logic          intPulse_q;
  logic          chargeDone_q;
  logic          switchOn_q;
  logic [35:0]   wdogCnt_q;
  logic          wdogExpired_q;
  logic [44:0]   safetyCnt_q;
  logic          safetyExpired_q;
  logic          halfPhase_q;

  i2c_reg_port u_port (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .sclIn  (sclIn),
    .sdaIn  (sdaIn),
    .sdaOe  (sdaOe),
    .rdData (rdData),
    .rdAddr (rdAddr),
    .req    (req)
  );

  function automatic logic [4:0] chargeHours(input logic [1:0] sel);
    case (sel)
      `CHG_SEL_5H:  chargeHours = `HOURS_5;
      `CHG_SEL_8H:  chargeHours = `HOURS_8;
      `CHG_SEL_12H: chargeHours = `HOURS_12;
      default:      chargeHours = `HOURS_20;
    endcase
  endfunction

  function automatic logic [35:0] wdogLimit(input logic [1:0] sel, input logic [35:0] unit);
    case (sel)
      `WDOG_40S: wdogLimit = unit;
      `WDOG_80S: wdogLimit = unit << 1;
      default:   wdogLimit = unit << 2;
    endcase
  endfunction

  // Register write decode
  wire wrTerm = req.wr && (req.addr == `OFS_TERM_TIMER);
  wire wrIr   = req.wr && (req.addr == `OFS_IR_COMP);
  wire wrMisc = req.wr && (req.addr == `OFS_MISC);

  // Read mux; status register is the live status word
  assign rdData = (rdAddr == `OFS_TERM_TIMER) ? termTimer_q :
                  (rdAddr == `OFS_IR_COMP)    ? irComp_q :
                  (rdAddr == `OFS_MISC)       ? misc_q :
                  (rdAddr == `OFS_STATUS)     ? sysStatus :
                  `RD_UNMAPPED;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      termTimer_q <= termTimerReg_t'(`RST_TERM_TIMER);
      irComp_q    <= irCompReg_t'(`RST_IR_COMP);
    end else begin
      if (wrTerm) termTimer_q <= termTimerReg_t'(req.data);
      if (wrIr) irComp_q <= irCompReg_t'(req.data);
    end
  end

  // Detection request bit is self-clearing; a new write wins over completion
  wire miscWrite = wrMisc;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      misc_q <= miscReg_t'(`RST_MISC);
    end else if (miscWrite) begin
      misc_q <= miscReg_t'(req.data);
    end else if (usbDetectDone) begin
      misc_q.usbDetectForce <= 1'b0;
    end
  end

  // Fault interrupts: new charge fault code or rising overvoltage, each masked
  wire chgFaultEvt = (chargeFaultCode != `FAULT_NONE) && (chargeFaultCode != faultPrev_q);
  wire ovFaultEvt  = batteryOvervoltFlag && !ovPrev_q;
  wire intNext     = (chgFaultEvt && misc_q.chargeFaultIntEn) ||
                     (ovFaultEvt && misc_q.batOvervoltIntEn);

  wire chargingNow = (sysStatus.chargePhase == `PHASE_PRE) ||
                     (sysStatus.chargePhase == `PHASE_FAST);
  wire doneNext    = (sysStatus.chargePhase == `PHASE_DONE) ||
                     (termTimer_q.termStatEarly && currentBelowEarly &&
                      (sysStatus.chargePhase == `PHASE_FAST));

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      faultPrev_q  <= `FAULT_NONE;
      ovPrev_q     <= 1'b0;
      intPulse_q   <= 1'b0;
      chargeDone_q <= 1'b0;
      switchOn_q   <= 1'b0;
    end else begin
      faultPrev_q  <= chargeFaultCode;
      ovPrev_q     <= batteryOvervoltFlag;
      intPulse_q   <= intNext;
      chargeDone_q <= doneNext;
      switchOn_q   <= batterySwitchReq && !misc_q.batterySwitchOff;
    end
  end

  // Host timeout: restarted by every register access, off when the field is 00
  wire        wdogKick     = req.wr || req.rd;
  wire        wdogOff      = (termTimer_q.hostTimeoutSel == `WDOG_OFF);
  wire [35:0] wdogLimitNow = wdogLimit(termTimer_q.hostTimeoutSel, WDOG_UNIT_CYCLES);

  always_ff @(posedge mclk) begin
    wdogExpired_q <= 1'b0;
    if (!rst_b || wdogKick || wdogOff) begin
      wdogCnt_q <= 36'd0;
    end else if (wdogCnt_q == wdogLimitNow - `WDOG_ONE) begin
      wdogCnt_q     <= 36'd0;
      wdogExpired_q <= 1'b1;
    end else begin
      wdogCnt_q <= wdogCnt_q + `WDOG_ONE;
    end
  end

  // Safety timer counts charging time; slowed cycles advance every other clock
  // Count saturates at the limit, so a limit lowered mid-charge still expires
  wire        safetyRun   = termTimer_q.safetyTimerEnable && chargingNow;
  wire        slowCond    = misc_q.slowSafetyClock &&
                            (sysStatus.inputLimitActive || sysStatus.thermalRegActive);
  wire [44:0] safetyLimit = 45'(chargeHours(termTimer_q.fastChargeLimitSel)) *
                            45'(HOUR_CYCLES);
  wire        safetyAdv   = safetyRun && (safetyCnt_q < safetyLimit) &&
                            (!slowCond || halfPhase_q);

  always_ff @(posedge mclk) begin
    if (!rst_b || !safetyRun) begin
      safetyCnt_q     <= 45'd0;
      safetyExpired_q <= 1'b0;
      halfPhase_q     <= 1'b0;
    end else begin
      halfPhase_q     <= slowCond && !halfPhase_q;
      safetyExpired_q <= (safetyCnt_q >= safetyLimit);
      if (safetyAdv) safetyCnt_q <= safetyCnt_q + `SAFETY_ONE;
    end
  end

  assign cfgTermTimer       = termTimer_q;
  assign cfgIrComp          = irComp_q;
  assign cfgMisc            = misc_q;
  assign chargeDoneInd      = chargeDone_q;
  assign hostTimeoutExpired = wdogExpired_q;
  assign safetyTimerExpired = safetyExpired_q;
  assign batterySwitchOn    = switchOn_q;
  assign intPulse           = intPulse_q;

  property p_term_readback;
    @(posedge mclk) disable iff (!rst_b)
      wrTerm |=> (termTimer_q == $past(req.data)) &&
                 (cfgTermTimer.termEnable == $past(req.data[7]));
  endproperty
  a_term_readback: assert property (p_term_readback) else $error("term reg write lost");

  property p_early_done;
    @(posedge mclk) disable iff (!rst_b)
      (termTimer_q.termStatEarly && currentBelowEarly && sysStatus.chargePhase == `PHASE_FAST)
      |=> chargeDoneInd;
  endproperty
  a_early_done: assert property (p_early_done) else $error("early done not shown");

  property p_wdog_off;
    @(posedge mclk) disable iff (!rst_b)
      hostTimeoutExpired |-> !$past(wdogOff) && !$past(wdogKick);
  endproperty
  a_wdog_off: assert property (p_wdog_off) else $error("timeout fired while off");

  property p_safety_enable;
    @(posedge mclk) disable iff (!rst_b)
      safetyTimerExpired |-> $past(termTimer_q.safetyTimerEnable) && $past(chargingNow);
  endproperty
  a_safety_enable: assert property (p_safety_enable) else $error("safety timer ran off");

  property p_safety_bound;
    @(posedge mclk) disable iff (!rst_b)
      (safetyRun && safetyCnt_q >= safetyLimit) |=> safetyTimerExpired;
  endproperty
  a_safety_bound: assert property (p_safety_bound) else $error("safety expiry missing");

  property p_ir_readback;
    @(posedge mclk) disable iff (!rst_b)
      wrIr |=> cfgIrComp == $past(req.data);
  endproperty
  a_ir_readback: assert property (p_ir_readback) else $error("ir comp write lost");

  property p_detect_clear;
    @(posedge mclk) disable iff (!rst_b)
      (usbDetectDone && !wrMisc) |=> !cfgMisc.usbDetectForce;
  endproperty
  a_detect_clear: assert property (p_detect_clear) else $error("detect bit not cleared");

  property p_half_rate;
    @(posedge mclk) disable iff (!rst_b)
      (slowCond && safetyAdv) |=> !(slowCond && safetyAdv);
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("slowed timer ran full rate");

  property p_switch_off;
    @(posedge mclk) disable iff (!rst_b)
      cfgMisc.batterySwitchOff |=> !batterySwitchOn;
  endproperty
  a_switch_off: assert property (p_switch_off) else $error("switch on while forced off");

  property p_int_cause;
    @(posedge mclk) disable iff (!rst_b)
      intPulse |-> $past(chgFaultEvt && misc_q.chargeFaultIntEn) ||
                   $past(ovFaultEvt && misc_q.batOvervoltIntEn);
  endproperty
  a_int_cause: assert property (p_int_cause) else $error("interrupt without cause");

  property p_ov_int;
    @(posedge mclk) disable iff (!rst_b)
      (ovFaultEvt && misc_q.batOvervoltIntEn) |=> intPulse;
  endproperty
  a_ov_int: assert property (p_ov_int) else $error("overvoltage interrupt missing");

  property p_status_read;
    @(posedge mclk) disable iff (!rst_b)
      (rdAddr == `OFS_STATUS) |-> rdData == sysStatus;
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read mismatch");

  property p_reset_values;
    @(posedge mclk)
      !rst_b |=> (termTimer_q == termTimerReg_t'(`RST_TERM_TIMER)) &&
                 (irComp_q == irCompReg_t'(`RST_IR_COMP)) &&
                 (misc_q == miscReg_t'(`RST_MISC));
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset value wrong");

  property p_charge_int;
    @(posedge mclk) disable iff (!rst_b)
      (chgFaultEvt && misc_q.chargeFaultIntEn) |=> intPulse;
  endproperty
  a_charge_int: assert property (p_charge_int) else $error("charge interrupt missing");

  property p_switch_on;
    @(posedge mclk) disable iff (!rst_b)
      (batterySwitchReq && !cfgMisc.batterySwitchOff) |=> batterySwitchOn;
  endproperty
  a_switch_on: assert property (p_switch_on) else $error("switch not allowed on");

  property p_done_phase;
    @(posedge mclk) disable iff (!rst_b)
      (sysStatus.chargePhase == `PHASE_DONE) |=> chargeDoneInd;
  endproperty
  a_done_phase: assert property (p_done_phase) else $error("done phase not shown");

  property p_misc_readback;
    @(posedge mclk) disable iff (!rst_b)
      wrMisc |=> cfgMisc == $past(req.data);
  endproperty
  a_misc_readback: assert property (p_misc_readback) else $error("misc reg write lost");

endmodule // charger_config_status_regs
`default_nettype wire

/* src/charger_regs_defines.svh */
// Constant names for the charger configuration and status register slice
`ifndef CHARGER_REGS_DEFINES_SVH
`define CHARGER_REGS_DEFINES_SVH

`define OFS_TERM_TIMER 8'h05
`define OFS_IR_COMP    8'h06
`define OFS_MISC       8'h07
`define OFS_STATUS     8'h08

`define RST_TERM_TIMER 8'h9a
`define RST_IR_COMP    8'h03
`define RST_MISC       8'h4b
`define RD_UNMAPPED    8'h00

// Target address on the two-wire bus (arbitrary value)
`define I2C_DEV_ADDR   7'h35
`define BYTE_BITS      4'd8
`define BIT_CNT_ZERO   4'd0
`define PTR_STEP       8'h01

`define PHASE_NONE     2'b00
`define PHASE_PRE      2'b01
`define PHASE_FAST     2'b10
`define PHASE_DONE     2'b11

`define SRC_UNKNOWN    2'b00
`define SRC_USB_HOST   2'b01
`define SRC_ADAPTER    2'b10
`define SRC_OTG        2'b11

`define FAULT_NONE     2'b00

`define WDOG_OFF       2'b00
`define WDOG_40S       2'b01
`define WDOG_80S       2'b10

`define CHG_SEL_5H     2'b00
`define CHG_SEL_8H     2'b01
`define CHG_SEL_12H    2'b10
`define HOURS_5        5'd5
`define HOURS_8        5'd8
`define HOURS_12       5'd12
`define HOURS_20       5'd20

`define CLK_HZ         64'd250000000
`define WDOG_UNIT_S    64'd40
`define HOUR_S         64'd3600

`define WDOG_ONE       36'd1
`define SAFETY_ONE     45'd1

`endif

/* src/charger_regs_pkg.sv */
// Types shared by the charger register slice and its two-wire port
`default_nettype none
package charger_regs_pkg;

  typedef struct packed {
    logic       termEnable;
    logic       termStatEarly;
    logic [1:0] hostTimeoutSel;
    logic       safetyTimerEnable;
    logic [1:0] fastChargeLimitSel;
    logic       rsvd0;
  } termTimerReg_t;

  typedef struct packed {
    logic [2:0] irResistanceSel;
    logic [2:0] irVoltageCeiling;
    logic [1:0] thermalLimitSel;
  } irCompReg_t;

  typedef struct packed {
    logic       usbDetectForce;
    logic       slowSafetyClock;
    logic       batterySwitchOff;
    logic [2:0] rsvd;
    logic       chargeFaultIntEn;
    logic       batOvervoltIntEn;
  } miscReg_t;

  typedef struct packed {
    logic [1:0] inputSourceKind;
    logic [1:0] chargePhase;
    logic       inputLimitActive;
    logic       powerGoodFlag;
    logic       thermalRegActive;
    logic       minSysRegFlag;
  } sysStatus_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
  } regReq_t;

  typedef enum {I2C_IDLE, I2C_ADDR, I2C_REG, I2C_WRITE, I2C_READ} i2cState_t;

endpackage
`default_nettype wire

/* src/i2c_reg_port.sv */
// Two-wire target that turns bus transfers into register write and read strobes
`include "charger_regs_defines.svh"
`default_nettype none
module i2c_reg_port
  import charger_regs_pkg::*;
(
  input  wire logic   mclk,
  input  wire logic   rst_b,
  input  wire logic   sclIn,
  input  wire logic   sdaIn,
  output var  logic   sdaOe,
  input  wire logic [7:0] rdData,
  output logic [7:0]  rdAddr,
  output regReq_t     req
);

  logic      sclM_q, sdaM_q, sclS_q, sdaS_q, sclD_q, sdaD_q;
  i2cState_t state_q;
  logic [3:0] bitCnt_q;
  logic       ackSlot_q;
  logic       nack_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  regReq_t    req_q;

  // Pins pass two flops; edges are taken from the second stage and its copy
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      {sclM_q, sdaM_q, sclS_q, sdaS_q, sclD_q, sdaD_q} <= 6'h3f;
    end else begin
      {sclM_q, sdaM_q} <= {sclIn, sdaIn};
      {sclS_q, sdaS_q} <= {sclM_q, sdaM_q};
      {sclD_q, sdaD_q} <= {sclS_q, sdaS_q};
    end
  end

  wire startSeen = sclS_q & sclD_q & sdaD_q & ~sdaS_q;
  wire stopSeen  = sclS_q & sclD_q & ~sdaD_q & sdaS_q;
  wire sclRise   = sclS_q & ~sclD_q;
  wire sclFall   = ~sclS_q & sclD_q;
  wire byteDone  = sclFall & ~ackSlot_q & (bitCnt_q == `BYTE_BITS);
  wire ackEnd    = sclFall & ackSlot_q;
  wire addrHit   = (shift_q[7:1] == `I2C_DEV_ADDR);

  always_ff @(posedge mclk) begin
    req_q.wr <= 1'b0;
    req_q.rd <= 1'b0;
    if (!rst_b) begin
      state_q    <= I2C_IDLE;
      bitCnt_q   <= `BIT_CNT_ZERO;
      ackSlot_q  <= 1'b0;
      nack_q     <= 1'b0;
      shift_q    <= 8'h00;
      tx_q       <= 8'h00;
      ptr_q      <= 8'h00;
      sdaOe      <= 1'b0;
      req_q.addr <= 8'h00;
      req_q.data <= 8'h00;
    end else if (startSeen) begin
      state_q   <= I2C_ADDR;
      bitCnt_q  <= `BIT_CNT_ZERO;
      ackSlot_q <= 1'b0;
      sdaOe     <= 1'b0;
    end else if (stopSeen) begin
      state_q   <= I2C_IDLE;
      ackSlot_q <= 1'b0;
      sdaOe     <= 1'b0;
    end else if (state_q != I2C_IDLE) begin
      if (sclRise && ackSlot_q) begin
        nack_q <= sdaS_q;
      end else if (sclRise) begin
        shift_q  <= {shift_q[6:0], sdaS_q};
        bitCnt_q <= bitCnt_q + 4'd1;
      end
      if (byteDone) begin
        ackSlot_q <= 1'b1;
        nack_q    <= 1'b0;
        case (state_q)
          I2C_ADDR: begin
            sdaOe   <= addrHit;
            state_q <= !addrHit ? I2C_IDLE : (shift_q[0] ? I2C_READ : I2C_REG);
          end
          I2C_REG: begin
            sdaOe   <= 1'b1;
            ptr_q   <= shift_q;
            state_q <= I2C_WRITE;
          end
          I2C_WRITE: begin
            sdaOe      <= 1'b1;
            req_q.wr   <= 1'b1;
            req_q.addr <= ptr_q;
            req_q.data <= shift_q;
            ptr_q      <= ptr_q + `PTR_STEP;
          end
          default: sdaOe <= 1'b0;
        endcase
      end else if (ackEnd) begin
        ackSlot_q <= 1'b0;
        bitCnt_q  <= `BIT_CNT_ZERO;
        sdaOe     <= 1'b0;
        if (state_q == I2C_READ) begin
          if (nack_q) begin
            state_q <= I2C_IDLE;
          end else begin
            tx_q       <= rdData;
            sdaOe      <= ~rdData[7];
            req_q.rd   <= 1'b1;
            req_q.addr <= ptr_q;
            ptr_q      <= ptr_q + `PTR_STEP;
          end
        end
      end else if (sclFall && state_q == I2C_READ && !ackSlot_q) begin
        tx_q  <= {tx_q[6:0], 1'b0};
        sdaOe <= ~tx_q[6];
      end
    end
  end

  assign rdAddr = ptr_q;
  assign req    = req_q;

endmodule // i2c_reg_port
`default_nettype wire

/* dv/i2c_host_model.sv */
// Two-wire bus controller model standing in for the host processor
`include "charger_regs_defines.svh"
`default_nettype none
module i2c_host_model (
  input  wire logic mclk,
  input  wire logic sdaOe,
  output var  logic sclIn,
  output wire logic sdaIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hostLow;
  logic nackSeen;
  // Open-drain data wire with pull-up: low while either side pulls
  assign sdaIn = ~(hostLow | sdaOe);
  initial begin
    sclIn = 1'b1;
    hostLow = 1'b0;
    nackSeen = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Each bus clock phase lasts 8 cycles; data moves only mid-low
  task automatic bit_io(input logic b, output logic r);
    hostLow <= ~b;
    tick(4);
    sclIn <= 1'b1;
    tick(8);
    r = sdaIn;
    sclIn <= 1'b0;
    tick(4);
  endtask
  task automatic start_cond;
    hostLow <= 1'b0;
    tick(4);
    sclIn <= 1'b1;
    tick(8);
    hostLow <= 1'b1;
    tick(8);
    sclIn <= 1'b0;
    tick(4);
  endtask
  task automatic stop_cond;
    hostLow <= 1'b1;
    tick(4);
    sclIn <= 1'b1;
    tick(8);
    hostLow <= 1'b0;
    tick(8);
  endtask
  task automatic put_byte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    nackSeen = nackSeen | r;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask
  task automatic write_regs(input logic [7:0] a, input int n, input logic [7:0] d [4]);
    nackSeen = 1'b0;
    start_cond();
    put_byte({`I2C_DEV_ADDR, 1'b0});
    put_byte(a);
    for (int i = 0; i < n; i++) put_byte(d[i]);
    stop_cond();
  endtask
  task automatic read_regs(input logic [7:0] a, input int n, output logic [7:0] q [4]);
    nackSeen = 1'b0;
    start_cond();
    put_byte({`I2C_DEV_ADDR, 1'b0});
    put_byte(a);
    start_cond();
    put_byte({`I2C_DEV_ADDR, 1'b1});
    for (int i = 0; i < n; i++) get_byte(i == n - 1, q[i]);
    stop_cond();
  endtask
endmodule // i2c_host_model
`default_nettype wire

/* dv/test_charger_config_status_regs.sv */
// Self-checking bench for the charger configuration and status registers
`default_nettype none
module test_charger_config_status_regs
  import charger_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 60000;
  logic          mclk;
  logic          rst_b;
  wire           sclIn;
  wire           sdaIn;
  logic          sdaOe;
  sysStatus_t    sysStatus;
  logic [1:0]    chargeFaultCode;
  logic          batteryOvervoltFlag;
  logic          usbDetectDone;
  logic          currentBelowEarly;
  logic          batterySwitchReq;
  termTimerReg_t cfgTermTimer;
  irCompReg_t    cfgIrComp;
  miscReg_t      cfgMisc;
  logic          chargeDoneInd;
  logic          hostTimeoutExpired;
  logic          safetyTimerExpired;
  logic          batterySwitchOn;
  logic          intPulse;
  int            fails = 0;
  int            nChecks = 0;
  int            cyc = 0;
  int            intCount = 0;
  int            hrs [4] = '{5, 8, 12, 20};

  i2c_host_model i_host (.mclk(mclk), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn));
  charger_config_status_regs #(.WDOG_UNIT_CYCLES(36'd200), .HOUR_CYCLES(40'd10)) i_dut (
    .mclk(mclk), .rst_b(rst_b), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOe(sdaOe),
    .sysStatus(sysStatus), .chargeFaultCode(chargeFaultCode),
    .batteryOvervoltFlag(batteryOvervoltFlag), .usbDetectDone(usbDetectDone),
    .currentBelowEarly(currentBelowEarly), .batterySwitchReq(batterySwitchReq),
    .cfgTermTimer(cfgTermTimer), .cfgIrComp(cfgIrComp), .cfgMisc(cfgMisc),
    .chargeDoneInd(chargeDoneInd), .hostTimeoutExpired(hostTimeoutExpired),
    .safetyTimerExpired(safetyTimerExpired), .batterySwitchOn(batterySwitchOn),
    .intPulse(intPulse));

  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    nChecks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v0, input logic [7:0] v1, input int n);
    logic [7:0] d [4];
    d = '{v0, v1, 8'h00, 8'h00};
    i_host.write_regs(a, n, d);
  endtask
  task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q [4];
    i_host.read_regs(a, 1, q);
    check(what, q[0], exp);
  endtask
  // Cycles until the chosen expiry output is seen, capped at 1000
  task automatic measure(input logic useSafety, output int c);
    c = 0;
    while (c < 1000 && (useSafety ? safetyTimerExpired : hostTimeoutExpired) !== 1'b1) begin
      @(negedge mclk);
      c++;
    end
    @(posedge mclk);
  endtask
  task automatic in_range(input string what, input int c, input int lo, input int hi);
    check(what, 8'(c >= lo && c <= hi), 8'h01);
  endtask

  always @(posedge mclk) begin
    intCount <= intCount + int'(intPulse === 1'b1);
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    logic [7:0] q [4];
    logic [7:0] d0;
    logic [7:0] d1;
    int c;
    rst_b = 1'b0;
    sysStatus = 8'h00;
    chargeFaultCode = 2'b00;
    batteryOvervoltFlag = 1'b0;
    usbDetectDone = 1'b0;
    currentBelowEarly = 1'b0;
    batterySwitchReq = 1'b1;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    rd("term reset", 8'h05, 8'h9a);
    rd("comp reset", 8'h06, 8'h03);
    rd("misc reset", 8'h07, 8'h4b);
    check("switch on", {7'h0, batterySwitchOn}, 8'h01);
    $display("test resets done");
    for (int k = 0; k < 4; k++) begin
      d0 = {2'b10, 2'(k), 1'b0, 2'(k), 1'b0};
      d1 = {3'(2 * k + 1), 3'(6 - 2 * k), 2'(k)};
      wr(8'h05, d0, d1, 2);
      check("ack", {7'h0, i_host.nackSeen}, 8'h00);
      i_host.read_regs(8'h05, 2, q);
      check("term readback", q[0], d0);
      check("comp readback", q[1], d1);
      check("term port", cfgTermTimer, d0);
      check("comp port", cfgIrComp, d1);
    end
    $display("test fields done");
    for (int k = 0; k < 4; k++) begin
      wr(8'h05, {2'b10, 2'(k), 4'h2}, 8'h00, 1);
      measure(1'b0, c);
      if (k == 0) in_range("timeout off", c, 1000, 1000);
      else in_range("timeout", c, (200 << (k - 1)) - 80, 200 << (k - 1));
    end
    $display("test host timeout done");
    for (int k = 0; k < 4; k++) begin
      wr(8'h05, {4'h8, 1'b1, 2'(k), 1'b0}, 8'h00, 1);
      sysStatus <= 8'h20;
      measure(1'b1, c);
      in_range("safety limit", c, hrs[k] * 10 - 2, hrs[k] * 10 + 4);
      sysStatus <= 8'h00;
    end
    wr(8'h05, 8'h88, 8'h00, 1);
    sysStatus <= 8'h22;
    measure(1'b1, c);
    in_range("slow safety", c, 98, 104);
    sysStatus <= 8'h00;
    wr(8'h07, 8'h0b, 8'h00, 1);
    sysStatus <= 8'h2a;
    measure(1'b1, c);
    in_range("normal safety", c, 48, 54);
    sysStatus <= 8'h00;
    wr(8'h05, 8'h80, 8'h00, 1);
    sysStatus <= 8'h20;
    measure(1'b1, c);
    in_range("safety off", c, 1000, 1000);
    sysStatus <= 8'h00;
    $display("test safety timer done");
    wr(8'h05, 8'hc0, 8'h00, 1);
    sysStatus <= 8'h20;
    currentBelowEarly <= 1'b1;
    repeat (3) @(posedge mclk);
    check("early done", {7'h0, chargeDoneInd}, 8'h01);
    wr(8'h05, 8'h80, 8'h00, 1);
    check("done follows term", {7'h0, chargeDoneInd}, 8'h00);
    sysStatus <= 8'h30;
    repeat (3) @(posedge mclk);
    check("done phase", {7'h0, chargeDoneInd}, 8'h01);
    currentBelowEarly <= 1'b0;
    $display("test done indication done");
    for (int k = 0; k < 4; k++) begin
      sysStatus <= 8'(k * 8'h55);
      rd("status", 8'h08, 8'(k * 8'h55));
    end
    wr(8'h08, 8'h00, 8'h00, 1);
    rd("status read only", 8'h08, 8'hff);
    rd("unmapped", 8'h09, 8'h00);
    wr(8'h0a, 8'h5a, 8'h00, 1);
    rd("unmapped write", 8'h0a, 8'h00);
    sysStatus <= 8'h00;
    $display("test status done");
    wr(8'h07, 8'hcb, 8'h00, 1);
    rd("detect set", 8'h07, 8'hcb);
    usbDetectDone <= 1'b1;
    @(posedge mclk);
    usbDetectDone <= 1'b0;
    repeat (2) @(posedge mclk);
    check("detect port", {7'h0, cfgMisc.usbDetectForce}, 8'h00);
    rd("detect clear", 8'h07, 8'h4b);
    $display("test detection done");
    chargeFaultCode <= 2'b01;
    repeat (3) @(posedge mclk);
    batteryOvervoltFlag <= 1'b1;
    repeat (3) @(posedge mclk);
    check("int count", 8'(intCount), 8'h02);
    wr(8'h07, 8'h68, 8'h00, 1);
    check("switch off", {7'h0, batterySwitchOn}, 8'h00);
    chargeFaultCode <= 2'b10;
    batteryOvervoltFlag <= 1'b0;
    @(posedge mclk);
    batteryOvervoltFlag <= 1'b1;
    repeat (3) @(posedge mclk);
    check("int masked", 8'(intCount), 8'h02);
    wr(8'h07, 8'h4b, 8'h00, 1);
    check("switch back", {7'h0, batterySwitchOn}, 8'h01);
    $display("test interrupts and switch done");
    give_verdict();
  end
endmodule // test_charger_config_status_regs
`default_nettype wire
